/* verilog/temp_sensor_conversion_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_regs
  import temp_sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = 7'h48,
  parameter int         CNT_W         = 24,
  parameter int         CONV_CYCLES   = CONV_CYC,
  parameter int         DELAY1_CYCLES = DLY1_CYC,
  parameter int         DELAY2_CYCLES = DLY2_CYC,
  parameter int         DELAY3_CYCLES = DLY3_CYC
) (
  // Core clock, reset and enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Converter sample
  input  wire logic [11:0] temp_sample_i,
  // Two-wire serial link
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Alert pin level
  output logic             alert_o
);

  // Counts below one, and conversion or third-delay counts too wide for CNT_W, are refused.
  if (CONV_CYCLES < 1 || DELAY1_CYCLES < 1 || DELAY2_CYCLES < 1 ||
      DELAY3_CYCLES < 1 || CONV_CYCLES >= 2**CNT_W ||
      DELAY3_CYCLES >= 2**CNT_W) begin : g_bad_cfg
    $error("temp_sensor_conversion_regs: counts do not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] DLY1_LAST = CNT_W'(DELAY1_CYCLES - 1);
  localparam logic [CNT_W-1:0] DLY2_LAST = CNT_W'(DELAY2_CYCLES - 1);
  localparam logic [CNT_W-1:0] DLY3_LAST = CNT_W'(DELAY3_CYCLES - 1);

  // ---------------- Link side: start and stop detection ----------------
  logic        start_tgl_q;
  logic        stop_tgl_q;

  // A falling data line while the clock is high marks a start.
  always_ff @(negedge sda_i or posedge rst_i) begin
    if (rst_i) start_tgl_q <= 1'b0;
    else if (scl_i) start_tgl_q <= ~start_tgl_q;
  end

  // A rising data line while the clock is high marks a stop.
  always_ff @(posedge sda_i or posedge rst_i) begin
    if (rst_i) stop_tgl_q <= 1'b0;
    else if (scl_i) stop_tgl_q <= ~stop_tgl_q;
  end

  // ---------------- Link side: byte engine on the serial clock ----------
  link_state_e lst_q, lst_d;
  logic        seen_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  sh_q;
  logic        ack_q, ack_d;
  logic [15:0] out_q;
  logic [1:0]  ptr_q;
  logic [7:0]  wr_hi_q;
  logic [15:0] wr_word_q;
  logic [1:0]  wr_ptr_q;
  logic        wr_tgl_q;
  logic        gc_tgl_q;
  logic [15:0] snap_q [4];

  // The start toggle is settled long before the first clock edge.
  wire       frame_new = start_tgl_q != seen_q;
  wire       byte_end  = !frame_new && bcnt_q == 4'h7;
  wire       ack_slot  = !frame_new && bcnt_q == 4'h8;
  wire [7:0] byte_w    = {sh_q[6:0], sda_i};
  wire       addr_hit  = byte_w[7:1] == DEV_ADDR;

  // Frame, bit count and shift register.
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
      bcnt_q <= 4'h0;
      sh_q   <= 8'h00;
    end else begin
      seen_q <= start_tgl_q;
      bcnt_q <= frame_new ? 4'h1 : (ack_slot ? 4'h0 : bcnt_q + 4'h1);
      sh_q   <= frame_new ? {7'h00, sda_i} : byte_w;
    end
  end

  // Link state and acknowledge decision for each received byte.
  always_comb begin
    lst_d = lst_q;
    ack_d = ack_q;
    if (frame_new) begin
      lst_d = LK_ADDR;
      ack_d = 1'b0;
    end else if (byte_end) begin
      case (lst_q)
        LK_ADDR: begin
          if (addr_hit) lst_d = byte_w[0] ? LK_READ : LK_PTR;
          else if (byte_w == GCALL_ADDR) lst_d = LK_GCALL;
          else lst_d = LK_IDLE;
        end
        LK_PTR:   lst_d = LK_MSB;
        LK_MSB:   lst_d = LK_LSB;
        LK_LSB:   lst_d = LK_IDLE;
        LK_GCALL: lst_d = LK_IDLE;
        default:  lst_d = lst_q;
      endcase
      case (lst_q)
        LK_ADDR:                 ack_d = lst_d != LK_IDLE;
        LK_PTR, LK_MSB, LK_LSB:  ack_d = 1'b1;
        LK_GCALL:                ack_d = byte_w == GCALL_CMD;
        default:                 ack_d = 1'b0;
      endcase
    end else if (ack_slot) begin
      ack_d = 1'b0;
      if (lst_q == LK_READ && sda_i) lst_d = LK_IDLE;
    end
  end

  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      lst_q <= LK_IDLE;
      ack_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      ack_q <= ack_d;
    end
  end

  // Selector, write word hand-off and read shifter.
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q     <= SELECT_RST[1:0];
      wr_hi_q   <= 8'h00;
      wr_word_q <= 16'h0000;
      wr_ptr_q  <= PTR_RESULT;
      wr_tgl_q  <= 1'b0;
      gc_tgl_q  <= 1'b0;
      out_q     <= 16'h0000;
    end else begin
      if (byte_end && lst_q == LK_PTR) ptr_q <= byte_w[1:0];
      if (byte_end && lst_q == LK_MSB) wr_hi_q <= byte_w;
      if (byte_end && lst_q == LK_LSB) begin
        wr_word_q <= {wr_hi_q, byte_w};
        wr_ptr_q  <= ptr_q;
        wr_tgl_q  <= ~wr_tgl_q;
      end
      if (byte_end && lst_q == LK_GCALL && byte_w == GCALL_CMD) begin
        gc_tgl_q <= ~gc_tgl_q;
        ptr_q    <= SELECT_RST[1:0];
      end
      if (byte_end && lst_q == LK_ADDR && lst_d == LK_READ) begin
        out_q <= snap_q[ptr_q];
      end else if (lst_q == LK_READ && !frame_new && bcnt_q != 4'h8) begin
        out_q <= {out_q[14:0], 1'b0};
      end
    end
  end

  // Data line driven on the falling clock: acknowledge or read bits.
  always_ff @(negedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      sda_oe_o <= (bcnt_q == 4'h8 && ack_q) ||
                  (lst_q == LK_READ && bcnt_q != 4'h8 && !out_q[15]);
      sda_o    <= 1'b0;
    end
  end

  // ---------------- Core side: crossings ----------------
  logic [3:0] sy1_q, sy2_q, sy3_q;
  logic       busy_q;

  // Bits: general call, write, stop, start; all are toggles.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
      sy3_q <= 4'h0;
    end else if (ce_i) begin
      sy1_q <= {gc_tgl_q, wr_tgl_q, stop_tgl_q, start_tgl_q};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  wire [3:0] ev_w     = sy2_q ^ sy3_q;
  wire       start_ev = ev_w[0];
  wire       stop_ev  = ev_w[1];
  wire       wr_ev    = ev_w[2];
  wire       gc_ev    = ev_w[3];

  // A bus frame freezes the snapshot that the link reads from.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) busy_q <= 1'b0;
    else if (ce_i) busy_q <= start_ev ? 1'b1 : (stop_ev ? 1'b0 : busy_q);
  end

  // ---------------- Core side: register fields ----------------
  logic [11:0] res_q, lo_q, hi_q;
  logic [1:0]  rate_q, fq_q;
  logic        pol_q, tm_q, sd_q, os_pend_q;
  conv_state_e st_q, st_d;

  wire wr_setup = wr_ev && wr_ptr_q == PTR_SETUP;
  wire os_set   = wr_setup && wr_word_q[CFG_OS_BIT] && wr_word_q[CFG_SD_BIT];
  wire os_take  = st_q == ST_SHUT && sd_q && os_pend_q;

  // Setup fields and limits; a general call restores reset values.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_q <= SETUP_RST[CFG_RATE_LSB+:2];
      fq_q   <= SETUP_RST[CFG_FQ_LSB+:2];
      pol_q  <= SETUP_RST[CFG_POL_BIT];
      tm_q   <= SETUP_RST[CFG_TM_BIT];
      sd_q   <= SETUP_RST[CFG_SD_BIT];
      lo_q   <= LOW_RST[15:4];
      hi_q   <= HIGH_RST[15:4];
    end else if (ce_i) begin
      if (gc_ev) begin
        rate_q <= SETUP_RST[CFG_RATE_LSB+:2];
        fq_q   <= SETUP_RST[CFG_FQ_LSB+:2];
        pol_q  <= SETUP_RST[CFG_POL_BIT];
        tm_q   <= SETUP_RST[CFG_TM_BIT];
        sd_q   <= SETUP_RST[CFG_SD_BIT];
        lo_q   <= LOW_RST[15:4];
        hi_q   <= HIGH_RST[15:4];
      end else if (wr_setup) begin
        rate_q <= wr_word_q[CFG_RATE_LSB+:2];
        fq_q   <= wr_word_q[CFG_FQ_LSB+:2];
        pol_q  <= wr_word_q[CFG_POL_BIT];
        tm_q   <= wr_word_q[CFG_TM_BIT];
        sd_q   <= wr_word_q[CFG_SD_BIT];
      end else if (wr_ev && wr_ptr_q == PTR_LOW) begin
        lo_q <= wr_word_q[15:4];
      end else if (wr_ev && wr_ptr_q == PTR_HIGH) begin
        hi_q <= wr_word_q[15:4];
      end
    end
  end

  // One-shot request; a new request wins over its own consumption.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) os_pend_q <= 1'b0;
    else if (ce_i) os_pend_q <= !gc_ev && (os_set || (os_pend_q && !os_take));
  end

  // ---------------- Core side: conversion sequencer ----------------
  logic [CNT_W-1:0] cnt_q;
  logic             shut_sig_q;

  wire [CNT_W-1:0] dly_last = rate_q == 2'h1 ? DLY1_LAST :
                              rate_q == 2'h2 ? DLY2_LAST : DLY3_LAST;
  wire conv_end  = st_q == ST_CONV && cnt_q == CONV_LAST;
  wire wait_end  = st_q == ST_WAIT && cnt_q == dly_last;
  wire shut_rise = st_d == ST_SHUT && !shut_sig_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_CONV: begin
        if (conv_end) begin
          if (sd_q) st_d = ST_SHUT;
          else if (rate_q == 2'h0) st_d = ST_CONV;
          else st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sd_q) st_d = ST_SHUT;
        else if (wait_end) st_d = ST_CONV;
      end
      ST_SHUT: begin
        if (!sd_q || os_pend_q) st_d = ST_CONV;
      end
      default: st_d = ST_CONV;
    endcase
  end

  // Reset and general call both restart a conversion at once.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= ST_CONV;
      cnt_q <= '0;
    end else if (ce_i) begin
      st_q  <= gc_ev ? ST_CONV : st_d;
      cnt_q <= (gc_ev || st_d != st_q || conv_end || wait_end) ? '0 : cnt_q + 1'b1;
    end
  end

  // Internal shutdown signal stays high through a one-shot conversion.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) shut_sig_q <= 1'b0;
    else if (ce_i) shut_sig_q <= !gc_ev && (st_d == ST_SHUT || (sd_q && shut_sig_q));
  end

  // The whole result changes in one cycle, never half at a time.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) res_q <= RESULT_RST[15:4];
    else if (ce_i && gc_ev) res_q <= RESULT_RST[15:4];
    else if (ce_i && conv_end) res_q <= temp_sample_i;
  end

  // ---------------- Core side: limit compare and alert ----------------
  logic [2:0] fcnt_q;
  logic       act_q, arm_hi_q;

  wire       arm_hi = tm_q ? arm_hi_q : !act_q;
  wire       fault  = arm_hi ? $signed(temp_sample_i) >= $signed(hi_q)
                             : $signed(temp_sample_i) < $signed(lo_q);
  wire [2:0] fnext  = fcnt_q + 3'h1;
  wire       hit    = fault && fnext == fq_need(fq_q);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) fcnt_q <= 3'h0;
    else if (ce_i && (gc_ev || shut_rise)) fcnt_q <= 3'h0;
    else if (ce_i && conv_end) fcnt_q <= (hit || !fault) ? 3'h0 : fnext;
  end

  // Comparator mode follows the limits; interrupt mode clears on bus access.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q    <= 1'b0;
      arm_hi_q <= 1'b1;
    end else if (ce_i) begin
      if (gc_ev || shut_rise) act_q <= 1'b0;
      else if (conv_end && hit) act_q <= tm_q ? 1'b1 : !act_q;
      else if (tm_q && start_ev) act_q <= 1'b0;
      if (gc_ev) arm_hi_q <= 1'b1;
      else if (conv_end && hit && tm_q) arm_hi_q <= !arm_hi_q;
    end
  end

  // Pin level: active low unless the polarity bit is set.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) alert_o <= 1'b1;
    else if (ce_i) alert_o <= ~(act_q ^ pol_q);
  end

  // ---------------- Core side: read snapshot ----------------
  logic [15:0] live_w [4];
  assign live_w[0] = {res_q, RESULT_RST[3:0]};
  assign live_w[1] = {1'b0, rate_q, fq_q, pol_q, tm_q, sd_q, SETUP_LOW};
  assign live_w[2] = {lo_q, LOW_RST[3:0]};
  assign live_w[3] = {hi_q, HIGH_RST[3:0]};

  for (genvar i = 0; i < 4; i++) begin : g_snap
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) snap_q[i] <= 16'h0000;
      else if (ce_i && !busy_q) snap_q[i] <= live_w[i];
    end
  end

  // ---------------- Checks ----------------
  logic [CNT_W-1:0] conv_len_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) conv_len_q <= '0;
    else if (ce_i) conv_len_q <= (st_q == ST_CONV && st_d == ST_CONV && !conv_end && !gc_ev) ?
                                 conv_len_q + 1'b1 : '0;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_os_start;
    st_q == ST_SHUT && sd_q && os_pend_q && ce_i && !gc_ev;
  endsequence

  a_conv_length: assert property (conv_end && ce_i |-> conv_len_q == CONV_LAST)
    else $error("conversion length wrong");
  a_result_store: assert property (conv_end && ce_i && !gc_ev |=> res_q == $past(temp_sample_i))
    else $error("result not stored");
  a_fast_rate: assert property (conv_end && ce_i && !gc_ev && !sd_q && rate_q == 2'h0
                                |=> st_q == ST_CONV && cnt_q == '0)
    else $error("default rate inserted delay");
  a_slow_rate: assert property (conv_end && ce_i && !gc_ev && !sd_q && rate_q != 2'h0
                                |=> st_q == ST_WAIT)
    else $error("slow rate did not wait");
  a_shut_late: assert property (st_q == ST_CONV && !conv_end && !gc_ev |=> st_q == ST_CONV)
    else $error("conversion cut short");
  a_shut_clear: assert property (shut_rise && ce_i && !gc_ev |=> !act_q && fcnt_q == 3'h0)
    else $error("shutdown did not clear alert");
  a_shut_hold: assert property (st_q == ST_SHUT && $past(st_q) == ST_SHUT && !tm_q && !gc_ev
                                |-> $stable(act_q))
    else $error("alert changed in shutdown");
  a_one_shot: assert property (s_os_start |=> st_q == ST_CONV ##0 !os_pend_q || os_set)
    else $error("one-shot did not start");
  a_os_zero: assert property (snap_q[1][CFG_OS_BIT] == 1'b0 && snap_q[1][7:0] != 8'h00
                              || busy_q || $past(rst_i))
    else $error("setup read image wrong");
  a_alert_level: assert property (ce_i ##1 ce_i |-> alert_o == ~($past(act_q) ^ $past(pol_q)))
    else $error("alert pin level wrong");

endmodule // temp_sensor_conversion_regs
`default_nettype wire

/* verilog/temp_sensor_pkg.sv */
`default_nettype none
package temp_sensor_pkg;

  // Core clock rate and the conversion timing derived from it.
  localparam int CLK_HZ       = 10_000_000;
  localparam int CONV_TIME_MS = 27;
  localparam int CONV_CYC     = CONV_TIME_MS * (CLK_HZ / 1000);

  // Typical conversion rates; the delay fills the rest of each period.
  localparam int RATE0_HZ = 37;
  localparam int RATE1_HZ = 18;
  localparam int RATE2_HZ = 9;
  localparam int RATE3_HZ = 4;
  localparam int DLY1_CYC = CLK_HZ / RATE1_HZ - CONV_CYC;
  localparam int DLY2_CYC = CLK_HZ / RATE2_HZ - CONV_CYC;
  localparam int DLY3_CYC = CLK_HZ / RATE3_HZ - CONV_CYC;

  // Register selector values.
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_SETUP  = 2'h1;
  localparam logic [1:0] PTR_LOW    = 2'h2;
  localparam logic [1:0] PTR_HIGH   = 2'h3;

  // Setup register field positions.
  localparam int CFG_OS_BIT   = 15;
  localparam int CFG_RATE_LSB = 13;
  localparam int CFG_FQ_LSB   = 11;
  localparam int CFG_POL_BIT  = 10;
  localparam int CFG_TM_BIT   = 9;
  localparam int CFG_SD_BIT   = 8;

  // Values after reset.
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] SETUP_RST  = 16'h00ff;
  localparam logic [15:0] LOW_RST    = 16'h4b00;
  localparam logic [15:0] HIGH_RST   = 16'h5000;
  localparam logic [7:0]  SELECT_RST = 8'h00;
  localparam logic [7:0]  SETUP_LOW  = 8'hff;

  // General-call address byte and reset command.
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [7:0] GCALL_CMD  = 8'h06;

  typedef enum logic [1:0] {ST_CONV, ST_WAIT, ST_SHUT} conv_state_e;
  typedef enum logic [2:0] {LK_ADDR, LK_PTR, LK_MSB, LK_LSB, LK_READ,
                            LK_GCALL, LK_IDLE} link_state_e;

  // Faults in a row needed to change the alert.
  function automatic logic [2:0] fq_need(input logic [1:0] fq);
    case (fq)
      2'h0:    fq_need = 3'h1;
      2'h1:    fq_need = 3'h2;
      2'h2:    fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  endfunction

endpackage
`default_nettype wire

/* test/temp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module temp_host_model (
  // Serial clock and open-drain pull of the data line
  output logic      scl_o,
  output logic      sda_pull_o,
  // Resolved data line level
  input  wire logic sda_i
);
  // The clock stands high and the line is released between frames.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Data changes while the clock is low and is read at the rising edge.
  task automatic xfer_bit(input logic b, output logic seen);
    #4 sda_pull_o = ~b;
    #12 scl_o = 1'b1;
    seen = sda_i;
    #16 scl_o = 1'b0;
  endtask

  // Start pulls data low while the clock is high.
  task automatic bus_start();
    #4 sda_pull_o = 1'b0;
    #12 scl_o = 1'b1;
    #16 sda_pull_o = 1'b1;
    #16 scl_o = 1'b0;
  endtask

  // Stop releases data while the clock is high, then leaves idle time.
  task automatic bus_stop();
    #4 sda_pull_o = 1'b1;
    #12 scl_o = 1'b1;
    #16 sda_pull_o = 1'b0;
    #500;
  endtask

  // Bytes go out most significant bit first; ack is a low line.
  task automatic put_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
    xfer_bit(1'b1, nak);
  endtask

  // Received byte, then the host's own ack or final nack.
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, s);
      d[i] = s;
    end
    xfer_bit(last, s);
  endtask

  // One whole write frame; any missing ack is reported.
  task automatic send(input logic [7:0] bytes[$], output logic nak);
    logic a;
    nak = 1'b0;
    bus_start();
    foreach (bytes[i]) begin
      put_byte(bytes[i], a);
      nak = nak | a;
    end
    bus_stop();
  endtask

  // Read of one word, upper byte first.
  task automatic read_word(input logic [7:0] adr, output logic [15:0] w, output logic nak);
    bus_start();
    put_byte(adr, nak);
    get_byte(1'b0, w[15:8]);
    get_byte(1'b1, w[7:0]);
    bus_stop();
  endtask
endmodule // temp_host_model
`default_nettype wire

/* test/temp_sensor_conversion_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_regs_test;
  import temp_sensor_pkg::*;
  localparam int         CONV = 20;
  localparam logic [7:0] WR   = 8'h90;
  localparam logic [7:0] RD   = 8'h91;

  // Stimulus, link wires and counters
  logic        core_clk_i;
  logic        rst_i;
  logic        ce_i;
  logic [11:0] temp_sample_i;
  logic        scl;
  logic        sda_pull;
  wire logic   sda_line;
  logic        sda_o;
  logic        sda_oe_o;
  logic        alert_o;
  int          n_mismatch;
  int          total_checks;

  // The pulled-up line goes low when either party pulls it.
  assign sda_line = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;

  temp_sensor_conversion_regs #(
    .CONV_CYCLES  (CONV),
    .DELAY1_CYCLES(5),
    .DELAY2_CYCLES(9),
    .DELAY3_CYCLES(13)
  ) i_dut (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .temp_sample_i(temp_sample_i),
    .scl_i        (scl),
    .sda_i        (sda_line),
    .sda_o        (sda_o),
    .sda_oe_o     (sda_oe_o),
    .alert_o      (alert_o)
  );

  temp_host_model i_host (
    .scl_o     (scl),
    .sda_pull_o(sda_pull),
    .sda_i     (sda_line)
  );

  // Core clock at 10 MHz.
  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic set_temp(input logic [11:0] v);
    @(posedge core_clk_i) temp_sample_i <= v;
  endtask

  task automatic wreg(input logic [1:0] sel, input logic [15:0] w);
    logic nak;
    i_host.send('{WR, {6'h00, sel}, w[15:8], w[7:0]}, nak);
    chk1("write ack", 1'b0, nak);
  endtask

  task automatic rreg(input logic [1:0] sel, input logic [15:0] exp, input string what);
    logic        nak;
    logic [15:0] w;
    i_host.send('{WR, {6'h00, sel}}, nak);
    chk1("select ack", 1'b0, nak);
    i_host.read_word(RD, w, nak);
    chk16(what, exp, w);
  endtask

  task automatic t_reset();
    cyc(CONV + 10);
    rreg(PTR_SETUP, 16'h00ff, "setup reset");
    rreg(PTR_LOW, 16'h4b00, "low reset");
    rreg(PTR_HIGH, 16'h5000, "high reset");
    rreg(PTR_RESULT, 16'h1900, "first result");
    chk1("alert idle", 1'b1, alert_o);
    @(posedge core_clk_i) ce_i <= 1'b0;
    set_temp(12'h3c0);
    cyc(3 * CONV);
    rreg(PTR_RESULT, 16'h1900, "result frozen while disabled");
    @(posedge core_clk_i) ce_i <= 1'b1;
    cyc(2 * CONV + 5);
    rreg(PTR_RESULT, 16'h3c00, "result after enable");
    $display("reset test done");
  endtask

  task automatic t_fields();
    wreg(PTR_SETUP, 16'hfe00);
    rreg(PTR_SETUP, 16'h7eff, "setup fields");
    chk1("alert high active idle", 1'b0, alert_o);
    wreg(PTR_SETUP, 16'h0000);
    wreg(PTR_LOW, 16'h123f);
    rreg(PTR_LOW, 16'h1230, "low nibble");
    wreg(PTR_HIGH, 16'h7ff5);
    rreg(PTR_HIGH, 16'h7ff0, "high nibble");
    wreg(PTR_RESULT, 16'h1234);
    rreg(PTR_RESULT, 16'h3c00, "result write dropped");
    wreg(PTR_LOW, 16'h4b00);
    wreg(PTR_HIGH, 16'h5000);
    set_temp(12'h2a8);
    cyc(2 * CONV + 5);
    rreg(PTR_RESULT, 16'h2a80, "result update");
    $display("field test done");
  endtask

  task automatic t_shutdown();
    wreg(PTR_SETUP, 16'h0100);
    cyc(CONV + 10);
    set_temp(12'h500);
    cyc(3 * CONV);
    rreg(PTR_RESULT, 16'h2a80, "frozen in shutdown");
    wreg(PTR_SETUP, 16'h8100);
    cyc(CONV + 10);
    chk1("alert after one shot", 1'b0, alert_o);
    rreg(PTR_RESULT, 16'h5000, "one shot result");
    set_temp(12'h190);
    cyc(3 * CONV);
    rreg(PTR_RESULT, 16'h5000, "one shot only once");
    wreg(PTR_SETUP, 16'h0100);
    cyc(10);
    chk1("alert kept on rewrite", 1'b0, alert_o);
    wreg(PTR_SETUP, 16'h0500);
    cyc(10);
    chk1("alert active high", 1'b1, alert_o);
    set_temp(12'h500);
    wreg(PTR_SETUP, 16'h0000);
    cyc(2 * CONV + 10);
    chk1("alert on hot", 1'b0, alert_o);
    wreg(PTR_SETUP, 16'h0100);
    cyc(2 * CONV + 10);
    chk1("alert cleared at shutdown", 1'b1, alert_o);
    $display("shutdown test done");
  endtask

  task automatic t_gcall();
    logic        nak;
    logic [15:0] w;
    wreg(PTR_SETUP, 16'h0200);
    i_host.send('{8'h00, 8'h06}, nak);
    chk1("general call ack", 1'b0, nak);
    i_host.read_word(RD, w, nak);
    chk16("result after general call", 16'h0000, w);
    cyc(CONV + 10);
    rreg(PTR_RESULT, 16'h5000, "conversion restarted");
    rreg(PTR_SETUP, 16'h00ff, "setup after general call");
    $display("general call test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    temp_sample_i = 12'h190;
    cyc(16);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_shutdown();
    t_gcall();
    end_of_test();
  end

  // A run that hangs is cut short.
  initial begin
    #1ms;
    n_mismatch++;
    $display("mismatch run time expected done seen hang");
    end_of_test();
  end
endmodule // temp_sensor_conversion_regs_test
`default_nettype wire
